//--- uav_pkg.sv
// Constants and types for the USB and FIFO interrupt autovector block.
// Assumes one processor clock and a synchronous active-high reset.
package uav_pkg;
  localparam int          USB_RANKS      = 32;
  localparam int          FIFO_RANKS     = 14;
  localparam logic [15:0] USB_VEC_ADDR   = 16'h0043;
  localparam logic [15:0] FIFO_VEC_ADDR  = 16'h0053;
  localparam logic [7:0]  USB_CODE_BASE  = 8'h00;
  localparam logic [7:0]  FIFO_CODE_BASE = 8'h80;
  localparam logic [7:0]  CODE_STEP      = 8'h04;
  // Ranks 6, 8, 18, 26, 27, 28 (indices 5, 7, 17, 25, 26, 27) hold no source
  localparam logic [31:0] USB_RESERVED   = 32'h0e02_00a0;
  localparam logic [7:0]  RESET_BYTE     = 8'h00;
  localparam logic        RESET_EN       = 1'b0;

  typedef struct packed {
    logic usb_autovector_enable;
    logic fifo_autovector_enable;
  } uav_setup_t;

  typedef struct packed {
    logic       pending;
    logic [7:0] code;
  } uav_vec_t;
endpackage

//--- uav_prio_enc.sv
// Priority encoder turning a pending vector into an autovector code.
// Assumes sources from logic on the same clock; lowest index wins.
`timescale 1ns/1ps
module uav_prio_enc #(
  parameter int          N    = 32,
  parameter logic [7:0]  BASE = 8'h00
) (
  input  wire logic [N-1:0] req_i,
  output uav_pkg::uav_vec_t vec_o
);
  always_comb begin
    vec_o.pending = 1'b0;
    vec_o.code    = BASE;
    // Scan downward so the lowest rank number is left standing
    for (int i = N - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        vec_o.pending = 1'b1;
        vec_o.code    = BASE + 8'(i) * uav_pkg::CODE_STEP;
      end
    end
  end
endmodule // uav_prio_enc

//--- uav_autovector.sv
// Second-level interrupt vectoring for USB and FIFO shared lines.
// Assumes event sources are on clk_i; the core fetches vector bytes by address.
`timescale 1ns/1ps
module uav_autovector (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire uav_pkg::uav_setup_t interrupt_setup_reg_i,
  input  wire logic                setup_data_ready_i,
  input  wire logic                start_of_frame_i,
  input  wire logic                setup_token_seen_i,
  input  wire logic                suspend_i,
  input  wire logic                bus_reset_i,
  input  wire logic                control_handshake_acked_i,
  input  wire logic [1:0]          ep0_buffer_i,
  input  wire logic [1:0]          ep1_buffer_i,
  input  wire logic [3:0]          ep_buffer_i,
  input  wire logic                in_bulk_nak_event_i,
  input  wire logic [5:0]          ping_nak_event_i,
  input  wire logic                bus_error_limit_hit_i,
  input  wire logic [3:0]          iso_sequence_error_i,
  input  wire logic [3:0]          programmable_level_flag_i,
  input  wire logic [3:0]          endpoint_empty_flag_i,
  input  wire logic [3:0]          endpoint_full_flag_i,
  input  wire logic                waveform_done_i,
  input  wire logic                waveform_event_i,
  input  wire logic [15:0]         fetch_addr_i,
  input  wire logic [7:0]          fetch_data_i,
  output logic                     usb_shared_irq_o,
  output logic                     fifo_shared_irq_o,
  output logic [7:0]               usb_vector_code_o,
  output logic [7:0]               fifo_vector_code_o,
  output logic [7:0]               fetch_data_o
);
  logic [31:0]       usb_req;
  logic [13:0]       fifo_req;
  uav_pkg::uav_vec_t usb_vec;
  uav_pkg::uav_vec_t fifo_vec;
  logic              usb_irq;
  logic              fifo_irq;
  logic [7:0]        usb_code;
  logic [7:0]        fifo_code;
  logic [7:0]        fetch_data;
  logic              next_usb_irq;
  logic              next_fifo_irq;
  logic [7:0]        next_usb_code;
  logic [7:0]        next_fifo_code;
  logic [7:0]        next_fetch_data;

  // Low operand byte sits two past the jump opcode at the vector
  function automatic logic is_low_byte(input logic [15:0] addr, input logic [15:0] vec);
    return addr == vec + 16'h0002;
  endfunction

  // Rank order by bit index; reserved ranks tied low
  always_comb begin
    usb_req      = '0;
    usb_req[0]   = setup_data_ready_i;
    usb_req[1]   = start_of_frame_i;
    usb_req[2]   = setup_token_seen_i;
    usb_req[3]   = suspend_i;
    usb_req[4]   = bus_reset_i;
    usb_req[6]   = control_handshake_acked_i;
    usb_req[9:8]   = ep0_buffer_i;
    usb_req[11:10] = ep1_buffer_i;
    usb_req[15:12] = ep_buffer_i;
    usb_req[16]    = in_bulk_nak_event_i;
    usb_req[23:18] = ping_nak_event_i;
    usb_req[24]    = bus_error_limit_hit_i;
    usb_req[31:28] = iso_sequence_error_i;
    usb_req = usb_req & ~uav_pkg::USB_RESERVED;
    fifo_req = {waveform_event_i, waveform_done_i, endpoint_full_flag_i,
                endpoint_empty_flag_i, programmable_level_flag_i};
  end

  uav_prio_enc #(
    .N    (uav_pkg::USB_RANKS),
    .BASE (uav_pkg::USB_CODE_BASE)
  ) u_usb_enc (
    .req_i (usb_req),
    .vec_o (usb_vec)
  );

  uav_prio_enc #(
    .N    (uav_pkg::FIFO_RANKS),
    .BASE (uav_pkg::FIFO_CODE_BASE)
  ) u_fifo_enc (
    .req_i (fifo_req),
    .vec_o (fifo_vec)
  );

  // Code held while idle so a late fetch still sees the last winner
  always_comb begin
    next_usb_irq    = usb_vec.pending;
    next_fifo_irq   = fifo_vec.pending;
    next_usb_code   = usb_vec.pending ? usb_vec.code : usb_code;
    next_fifo_code  = fifo_vec.pending ? fifo_vec.code : fifo_code;
    next_fetch_data = fetch_data_i;
    // Page byte one past the opcode is never touched
    if (interrupt_setup_reg_i.usb_autovector_enable &&
        is_low_byte(fetch_addr_i, uav_pkg::USB_VEC_ADDR)) begin
      next_fetch_data = next_usb_code;
    end else if (interrupt_setup_reg_i.fifo_autovector_enable &&
                 is_low_byte(fetch_addr_i, uav_pkg::FIFO_VEC_ADDR)) begin
      next_fetch_data = next_fifo_code;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      usb_irq    <= 1'b0;
      fifo_irq   <= 1'b0;
      usb_code   <= uav_pkg::RESET_BYTE;
      fifo_code  <= uav_pkg::FIFO_CODE_BASE;
      fetch_data <= uav_pkg::RESET_BYTE;
    end else begin
      usb_irq    <= next_usb_irq;
      fifo_irq   <= next_fifo_irq;
      usb_code   <= next_usb_code;
      fifo_code  <= next_fifo_code;
      fetch_data <= next_fetch_data;
    end
  end

  assign usb_shared_irq_o   = usb_irq;
  assign fifo_shared_irq_o  = fifo_irq;
  assign usb_vector_code_o  = usb_code;
  assign fifo_vector_code_o = fifo_code;
  assign fetch_data_o       = fetch_data;
endmodule // uav_autovector

//--- uav_core_model.sv
// Core model: fetches vector low bytes.
// Assumes go_i changes after the edge.
`timescale 1ns/1ps
module uav_core_model (
  input  wire logic        clk_i,
  input  wire logic [1:0]  go_i,
  output logic      [15:0] fetch_addr_o = 16'h0100,
  output logic      [7:0]  fetch_data_o = 8'h00
);
  // Data moves every cycle so a stale byte cannot pass
  always @(posedge clk_i) begin
    // Both bits set fetches a page byte, which must pass untouched
    fetch_addr_o <= go_i == 2'h3 ? {8'h00, fetch_data_o[0] ? 8'h54 : 8'h44} :
                    go_i[0] ? 16'h0045 : go_i[1] ? 16'h0055 : {8'h01, fetch_data_o};
    fetch_data_o <= fetch_data_o + 8'h35;
  end
endmodule // uav_core_model

//--- uav_autovector_checker.sv
// Port checker.
// Bound below; one clock.
`timescale 1ns/1ps
module uav_autovector_checker (
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire uav_pkg::uav_setup_t interrupt_setup_reg_i,
  input wire logic                setup_data_ready_i,
  input wire logic [15:0]         fetch_addr_i,
  input wire logic [7:0]          fetch_data_i,
  input wire logic                usb_shared_irq_o,
  input wire logic [7:0]          usb_vector_code_o,
  input wire logic [7:0]          fifo_vector_code_o,
  input wire logic [7:0]          fetch_data_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_top_code: assert property (setup_data_ready_i |=> usb_vector_code_o == 8'h00)
    else $error("top");
  chk_usb_swap: assert property (interrupt_setup_reg_i[1] && fetch_addr_i == 16'h0045
    |=> fetch_data_o == usb_vector_code_o) else $error("usb");
  chk_fifo_swap: assert property (interrupt_setup_reg_i[0] && fetch_addr_i == 16'h0055
    |=> fetch_data_o == fifo_vector_code_o) else $error("fifo");
  chk_plain_pass: assert property (interrupt_setup_reg_i == 2'h0
    |=> fetch_data_o == $past(fetch_data_i)) else $error("pass");
  chk_usb_gap: assert property (!(usb_vector_code_o inside
    {8'h14, 8'h1c, 8'h44, 8'h64, 8'h68, 8'h6c})) else $error("gap");
  chk_code_step: assert property (fifo_vector_code_o inside {[8'h80:8'hb4]}
    && fifo_vector_code_o[1:0] == 2'h0) else $error("step");
  chk_usb_hold: assert property (!usb_shared_irq_o && !$past(rst_i)
    |-> $stable(usb_vector_code_o)) else $error("hold");
  chk_far_pass: assert property (fetch_addr_i[15:8] != 8'h00
    |=> fetch_data_o == $past(fetch_data_i)) else $error("far");
  chk_page_keep: assert property (fetch_addr_i == 16'h0044 || fetch_addr_i == 16'h0054
    |=> fetch_data_o == $past(fetch_data_i)) else $error("page");
endmodule // uav_autovector_checker
bind uav_autovector uav_autovector_checker uav_autovector_checker_i (
  .clk_i                 (clk_i),
  .rst_i                 (rst_i),
  .interrupt_setup_reg_i (interrupt_setup_reg_i),
  .setup_data_ready_i    (setup_data_ready_i),
  .fetch_addr_i          (fetch_addr_i),
  .fetch_data_i          (fetch_data_i),
  .usb_shared_irq_o      (usb_shared_irq_o),
  .usb_vector_code_o     (usb_vector_code_o),
  .fifo_vector_code_o    (fifo_vector_code_o),
  .fetch_data_o          (fetch_data_o)
);

//--- uav_autovector_test.sv
// Bench: random sources and fetches.
// Assumes the core model above.
`timescale 1ns/1ps
module uav_autovector_test;
  logic        clk_i = 0, rst_i = 1, ui, fi;
  logic [31:0] u = '0;
  logic [13:0] f = '0;
  logic [1:0]  go = '0, cfg = '0;
  logic [15:0] fa;
  logic [7:0]  fd, uc, fc, fo, eu = 8'h00, ef = 8'h80, efd = 8'h00;
  logic [25:0] got, exp;
  int          n_fail = 0, compares = 0;
  // Only ranks that own a port; reserved ranks have none
  localparam logic [31:0] USB_WIRED = 32'hf1fd_ff5f;
  always #12.5 clk_i = ~clk_i;
  uav_core_model uav_core_model_i (.clk_i, .go_i(go), .fetch_addr_o(fa), .fetch_data_o(fd));
  uav_autovector uav_autovector_i (.clk_i, .rst_i, .interrupt_setup_reg_i(cfg),
    .setup_data_ready_i(u[0]), .start_of_frame_i(u[1]), .setup_token_seen_i(u[2]),
    .suspend_i(u[3]), .bus_reset_i(u[4]), .control_handshake_acked_i(u[6]),
    .ep0_buffer_i(u[9:8]), .ep1_buffer_i(u[11:10]), .ep_buffer_i(u[15:12]),
    .in_bulk_nak_event_i(u[16]), .ping_nak_event_i(u[23:18]),
    .bus_error_limit_hit_i(u[24]), .iso_sequence_error_i(u[31:28]),
    .programmable_level_flag_i(f[3:0]), .endpoint_empty_flag_i(f[7:4]),
    .endpoint_full_flag_i(f[11:8]), .waveform_done_i(f[12]), .waveform_event_i(f[13]),
    .fetch_addr_i(fa), .fetch_data_i(fd), .usb_shared_irq_o(ui), .fifo_shared_irq_o(fi),
    .usb_vector_code_o(uc), .fifo_vector_code_o(fc), .fetch_data_o(fo));
  function automatic logic [7:0] pick(logic [31:0] v, logic [7:0] b, logic [7:0] r);
    for (int i = 31; i >= 0; i--) if (v[i]) r = b + 8'(4 * i);
    return r;
  endfunction
  task automatic report_and_stop;
    if (n_fail == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h92dd7b40));
    repeat (4) @(posedge clk_i);
    #1 rst_i = 0;
    for (int n = 0; n < 300; n++) begin
      got = {uc, fc, fo, ui, fi};
      exp = {eu, ef, efd, |u, |f};
      compares++;
      if (got !== exp) begin
        n_fail++;
        $display("wrong value at %0t: %h, expected %h", $time, got, exp);
      end
      // One-hot walk first, then sparse mixes so ranks compete
      u = n < 32 ? 32'h1 << n : n == 40 ? '1 : $urandom & $urandom & $urandom;
      u = u & USB_WIRED;
      f = n < 14 ? 14'h1 << n : n == 40 ? '1 : 14'($urandom & $urandom);
      cfg = 2'($urandom);
      go = 2'($urandom);
      eu = pick(u, 8'h00, eu);
      ef = pick(32'(f), 8'h80, ef);
      efd = fa == 16'h0045 && cfg[1] ? eu : fd;
      if (fa == 16'h0055 && cfg[0]) efd = ef;
      // Mid-run reset: every output returns to its reset value
      rst_i = n == 150;
      if (rst_i) begin
        u   = '0;
        f   = '0;
        eu  = 8'h00;
        ef  = 8'h80;
        efd = 8'h00;
      end
      @(posedge clk_i);
      #1;
    end
    report_and_stop;
  end
endmodule // uav_autovector_test
